// *** gpdc_pkg.sv ***
// Package for the global power down sequencer: register map, timing, types.
// Assumes a single SDRAM-domain clock of 25 MHz and an MMIO request port.
// Notes on behaviour
// RULE1 - Global sleep starts only on an MMIO write to the sleep trigger register.
// RULE2 - The triggering write stays uncompleted for the whole sleep period.
// RULE3 - On wake-up the held trigger write is completed.
// RULE4 - Core finishes earlier instructions before sleep, later ones only after wake.
// RULE5 - Any interrupt accepted by the interrupt controller wakes the chip.
// RULE6 - A highway memory request from a running unit wakes the chip.
// RULE7 - PLLs, interrupt logic, timers, wake logic, PCI and sleepless units stay powered.
// RULE8 - Entering sleep stops most clocks and puts SDRAM into self-refresh.
// RULE9 - Sleep cuts all peripherals except boot, caches, PCI, timers, vectored IRQ unit.
// RULE10 - Selected peripherals may be excluded from global power down.
// RULE11 - A per-block shutdown register powers chosen blocks down independently.
// RULE12 - Trigger write leaves shutoff register alone; shutoff write never triggers sleep.
// RULE13 - Before sleep, wait until any SDRAM transfer in progress has finished.
// RULE14 - Wake order: drop sleep signal, leave self-refresh, then complete the write.
// RULE15 - Sleep trigger register holds nothing; reads return undefined, no side effect.
// RULE16 - Shutoff bit one powers its block off; zero restores power.
package gpdc_pkg;
    localparam logic [23:0] GSLEEP_TRIG_OFS = 24'h100108;
    localparam logic [23:0] UNIT_SHUTOFF_OFS = 24'h103428;
    localparam logic [31:0] UNIT_SHUTOFF_RST = 32'h00000000;
    localparam logic [31:0] TRIG_READ_VALUE = 32'h00000000;
    localparam int NUM_UNITS = 16;
    // Self-refresh exit time in ns (SDRAM needs time before first access)
    localparam int SR_EXIT_NS = 200;
    localparam int CLK_MHZ = 25;
    localparam int SR_EXIT_CYC = (SR_EXIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] SR_EXIT_CNT = 4'(SR_EXIT_CYC);

    typedef enum logic [2:0] {
        GPDC_IDLE = 3'b000,
        GPDC_DRAIN = 3'b001,
        GPDC_SLEEP = 3'b011,
        GPDC_WAKE = 3'b010,
        GPDC_SREXIT = 3'b110,
        GPDC_DONE = 3'b111
    } gpdc_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] addr;
        logic [31:0] wdata;
    } gpdc_mmio_req_t;

    typedef struct packed {
        logic done;
        logic [31:0] rdata;
    } gpdc_mmio_rsp_t;
endpackage : gpdc_pkg

// *** gpdc_sync.sv ***
// Two-flop synchroniser vector for wake sources arriving from outside logic.
// Assumes inputs may be asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module gpdc_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : gpdc_sync
`default_nettype wire

// *** gpdc_seq.sv ***
// Global power down sequencer with per-unit shutoff register.
// Assumes an MMIO port that holds a request until done, and an SDRAM
// controller that reports busy and acknowledges self-refresh entry.
`timescale 1ns/10ps
`default_nettype none
module gpdc_seq #(
    parameter int NUM_UNITS = gpdc_pkg::NUM_UNITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // MMIO request and response
    input wire gpdc_pkg::gpdc_mmio_req_t mmio_req,
    output gpdc_pkg::gpdc_mmio_rsp_t mmio_rsp,
    // Wake sources
    input wire logic irq_accepted,
    input wire logic highway_req,
    // SDRAM controller handshake
    input wire logic sdram_busy,
    input wire logic sdram_sr_ack,
    output logic sdram_sr_req,
    // Power controls
    input wire logic [NUM_UNITS-1:0] sleepless,
    output logic global_sleep,
    output logic [NUM_UNITS-1:0] unit_clk_off,
    output logic [NUM_UNITS-1:0] unit_power_off
);
    gpdc_pkg::gpdc_state_t state_reg, state_next;
    logic [NUM_UNITS-1:0] shutoff_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [1:0] wake_sync;
    logic [31:0] rdata_reg;
    logic done_reg;
    logic sleep_reg, sr_reg;

    gpdc_sync #(.WIDTH(2)) u_wake_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({irq_accepted, highway_req}),
        .sync_out(wake_sync)
    );

    // Address decode
    wire hit_trig = mmio_req.valid && mmio_req.addr == gpdc_pkg::GSLEEP_TRIG_OFS;
    wire hit_shut = mmio_req.valid && mmio_req.addr == gpdc_pkg::UNIT_SHUTOFF_OFS;
    wire trig_write = hit_trig && mmio_req.write; // RULE1
    wire shut_write = hit_shut && mmio_req.write && !done_reg;
    wire wake = wake_sync[1] | wake_sync[0]; // RULE5 RULE6
    wire idle = state_reg == gpdc_pkg::GPDC_IDLE;
    // Non-trigger accesses finish in one cycle; trigger write is held
    wire plain_done = mmio_req.valid && !trig_write && idle && !done_reg;

    // Next state of the sleep sequence
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            gpdc_pkg::GPDC_IDLE: if (trig_write && !done_reg) state_next = gpdc_pkg::GPDC_DRAIN;
            gpdc_pkg::GPDC_DRAIN: if (!sdram_busy && sdram_sr_ack) begin // RULE13 RULE8
                state_next = gpdc_pkg::GPDC_SLEEP;
            end
            gpdc_pkg::GPDC_SLEEP: if (wake) state_next = gpdc_pkg::GPDC_WAKE;
            gpdc_pkg::GPDC_WAKE: begin
                state_next = gpdc_pkg::GPDC_SREXIT; // RULE14
                cnt_next = gpdc_pkg::SR_EXIT_CNT;
            end
            gpdc_pkg::GPDC_SREXIT: begin
                if (!sdram_sr_ack && cnt_reg <= 4'h1) state_next = gpdc_pkg::GPDC_DONE;
                if (cnt_reg != 4'h0) cnt_next = cnt_reg - 4'h1;
            end
            gpdc_pkg::GPDC_DONE: state_next = gpdc_pkg::GPDC_IDLE; // RULE3
            default: state_next = gpdc_pkg::GPDC_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= gpdc_pkg::GPDC_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Sleep and self-refresh controls
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_reg <= 1'b0;
            sr_reg <= 1'b0;
        end else begin
            sr_reg <= state_next == gpdc_pkg::GPDC_DRAIN && !sdram_busy
                || state_next == gpdc_pkg::GPDC_SLEEP; // RULE8 RULE13
            sleep_reg <= state_next == gpdc_pkg::GPDC_SLEEP; // RULE2 RULE14
        end
    end

    // Shutoff register and MMIO response; trigger write never touches it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shutoff_reg <= gpdc_pkg::UNIT_SHUTOFF_RST[NUM_UNITS-1:0];
            rdata_reg <= 32'h00000000;
            done_reg <= 1'b0;
        end else begin
            if (shut_write && idle) shutoff_reg <= mmio_req.wdata[NUM_UNITS-1:0]; // RULE11 RULE12 RULE16
            done_reg <= plain_done || state_reg == gpdc_pkg::GPDC_DONE; // RULE2 RULE3 RULE4
            if (hit_shut && !mmio_req.write) begin
                rdata_reg <= 32'(shutoff_reg);
            end else begin
                rdata_reg <= gpdc_pkg::TRIG_READ_VALUE; // RULE15
            end
        end
    end

    // Outputs; always-on units (PLL, IRQ, timers, PCI, caches) are outside these vectors
    assign global_sleep = sleep_reg;
    assign sdram_sr_req = sr_reg;
    assign unit_clk_off = {NUM_UNITS{sleep_reg}} & ~sleepless; // RULE7 RULE9 RULE10
    assign unit_power_off = shutoff_reg | ({NUM_UNITS{sleep_reg}} & ~sleepless); // RULE9 RULE11
    assign mmio_rsp.done = done_reg;
    assign mmio_rsp.rdata = rdata_reg;

    // Completion checks: the trigger write is held, other accesses finish at once
    a_no_done_sleep: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        global_sleep |-> !mmio_rsp.done)
        else $error("write completed while asleep");

    a_held_busy: assert property (@(posedge clk) disable iff (!reset_n) // RULE2 RULE4
        (!idle && state_reg != gpdc_pkg::GPDC_DONE) |=> !mmio_rsp.done)
        else $error("access completed during sequence");

    a_sleep_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        (state_reg == gpdc_pkg::GPDC_SLEEP && !wake) |=> global_sleep && !mmio_rsp.done)
        else $error("sleep left without wake");

    a_done_pulse: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        mmio_rsp.done |=> !mmio_rsp.done)
        else $error("completion longer than one cycle");

    a_done_idle: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        (state_reg == gpdc_pkg::GPDC_DONE) |=> idle && mmio_rsp.done)
        else $error("held write not completed");

    a_wake_bound: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        (global_sleep && wake) |-> ##[1:20] mmio_rsp.done)
        else $error("wake not completed");

    a_trig_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
        (hit_trig && !mmio_req.write && idle && !done_reg)
        |=> mmio_rsp.done && idle && mmio_rsp.rdata == gpdc_pkg::TRIG_READ_VALUE)
        else $error("trigger read had a side effect");

    // Sequence checks: entry only by trigger, drain first, ordered wake
    a_trig_only: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        (idle && !trig_write) |=> !global_sleep)
        else $error("sleep without trigger");

    a_trig_start: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        (trig_write && idle && !done_reg) |=> state_reg == gpdc_pkg::GPDC_DRAIN)
        else $error("trigger write not taken");

    a_drain_wait: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        (state_reg == gpdc_pkg::GPDC_DRAIN && sdram_busy) |=> !global_sleep)
        else $error("slept during transfer");

    a_drain_sr_low: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        (state_reg == gpdc_pkg::GPDC_DRAIN && sdram_busy) |=> !sdram_sr_req)
        else $error("self-refresh asked during transfer");

    a_drain_enter: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
        (state_reg == gpdc_pkg::GPDC_DRAIN && !sdram_busy && sdram_sr_ack)
        |=> global_sleep && sdram_sr_req)
        else $error("sleep not entered");

    a_sr_in_sleep: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
        global_sleep |-> sdram_sr_req)
        else $error("SDRAM not in self-refresh");

    a_wake_leave: assert property (@(posedge clk) disable iff (!reset_n) // RULE5 RULE6
        (state_reg == gpdc_pkg::GPDC_SLEEP && wake) |=> !global_sleep ##0 $past(global_sleep))
        else $error("sleep not dropped");

    a_wake_count: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        (state_reg == gpdc_pkg::GPDC_WAKE)
        |=> state_reg == gpdc_pkg::GPDC_SREXIT && cnt_reg == gpdc_pkg::SR_EXIT_CNT)
        else $error("self-refresh exit not started");

    a_srexit_sr_low: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        (state_reg == gpdc_pkg::GPDC_SREXIT) |-> !sdram_sr_req)
        else $error("self-refresh still asked on exit");

    a_srexit_ack_wait: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        (state_reg == gpdc_pkg::GPDC_SREXIT && sdram_sr_ack)
        |=> state_reg == gpdc_pkg::GPDC_SREXIT)
        else $error("left exit while SDRAM in self-refresh");

    a_srexit_time: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        $rose(state_reg == gpdc_pkg::GPDC_SREXIT) |-> !mmio_rsp.done [*5])
        else $error("completed before exit time");

    a_wake_order: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        $fell(global_sleep) |-> !mmio_rsp.done [*3])
        else $error("done before SR exit");

    // Register and power checks
    a_shut_keep: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        trig_write |=> $stable(shutoff_reg))
        else $error("shutoff changed by trigger");

    a_shut_done: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        (shut_write && idle) |=> mmio_rsp.done && !global_sleep)
        else $error("shutoff write misbehaved");

    a_shut_set: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
        (shut_write && idle && mmio_req.wdata[0]) |=> unit_power_off[0])
        else $error("shutoff bit did not power off");

    a_shut_clear: assert property (@(posedge clk) disable iff (!reset_n) // RULE16
        (shut_write && idle && !mmio_req.wdata[0]) |=> !unit_power_off[0])
        else $error("cleared shutoff bit kept power off");

    a_sleepless: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
        (unit_clk_off & sleepless) == '0)
        else $error("sleepless unit stopped");
endmodule : gpdc_seq
`default_nettype wire

// *** gpdc_sdram_model.sv ***
// SDRAM controller stand-in: transfer busy window, self-refresh handshake.
// Assumes the sequencer clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module gpdc_sdram_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Handshake
    input wire logic start_xfer,
    input wire logic sr_req,
    output logic busy,
    output logic sr_ack
);
    logic [2:0] xfer_reg;
    logic sr_dly_reg;
    // Busy four cycles per transfer; ack follows request two cycles late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xfer_reg <= 3'h0;
            sr_dly_reg <= 1'b0;
            sr_ack <= 1'b0;
        end else begin
            xfer_reg <= start_xfer ? 3'h4 : xfer_reg - 3'(xfer_reg != 3'h0);
            sr_dly_reg <= sr_req;
            sr_ack <= sr_dly_reg;
        end
    end
    assign busy = (xfer_reg != 3'h0);
endmodule : gpdc_sdram_model
`default_nettype wire

// *** gpdc_seq_tb.sv ***
// Self-checking bench for the global power down sequencer.
// Assumes the SDRAM stand-in model and a 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module gpdc_seq_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    gpdc_pkg::gpdc_mmio_req_t mmio_req = '0;
    gpdc_pkg::gpdc_mmio_rsp_t mmio_rsp;
    logic irq_accepted = 1'b0;
    logic highway_req = 1'b0;
    logic start_xfer = 1'b0;
    logic sdram_busy, sdram_sr_ack, sdram_sr_req, global_sleep;
    logic [15:0] sleepless = 16'h0000;
    logic [15:0] unit_clk_off, unit_power_off;
    logic [31:0] rd;
    int mismatches = 0;
    int total_checks = 0;
    int sleeps = 0;
    int n;
    always #20 clk = ~clk;
    gpdc_seq uut (.clk(clk), .reset_n(reset_n), .mmio_req(mmio_req), .mmio_rsp(mmio_rsp),
        .irq_accepted(irq_accepted), .highway_req(highway_req), .sdram_busy(sdram_busy),
        .sdram_sr_ack(sdram_sr_ack), .sdram_sr_req(sdram_sr_req), .sleepless(sleepless),
        .global_sleep(global_sleep), .unit_clk_off(unit_clk_off),
        .unit_power_off(unit_power_off));
    gpdc_sdram_model sdram (.clk(clk), .reset_n(reset_n), .start_xfer(start_xfer),
        .sr_req(sdram_sr_req), .busy(sdram_busy), .sr_ack(sdram_sr_ack));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One MMIO access, held until done
    task automatic access(input logic wr, input logic [23:0] addr, input logic [31:0] wd);
        int k;
        k = 0;
        @(negedge clk);
        mmio_req = '{valid: 1'b1, write: wr, addr: addr, wdata: wd};
        do begin
            @(negedge clk);
            k++;
        end while (mmio_rsp.done !== 1'b1 && k < 400);
        if (k >= 400) mismatches++;
        rd = mmio_rsp.rdata;
        mmio_req = '0;
    endtask : access
    // Verdict
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Watchers on completion, drain and sleep entries
    always @(posedge global_sleep) sleeps++;
    always @(negedge clk) begin
        if (mmio_rsp.done === 1'b1) check({global_sleep, sdram_sr_ack}, 2'b00);
        if (global_sleep === 1'b1 && mmio_rsp.done === 1'b1) check(1, 0);
        if (sdram_sr_req === 1'b1 && sdram_busy === 1'b1) check(1, 0);
    end
    initial begin
        #(40 * 4000);
        mismatches++;
        stop_test;
    end
    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check({global_sleep, unit_power_off}, 17'h0);
        access(1'b1, gpdc_pkg::UNIT_SHUTOFF_OFS, 32'h0000A5A5);
        check(unit_power_off, 16'hA5A5);
        access(1'b0, gpdc_pkg::UNIT_SHUTOFF_OFS, 32'h0);
        check(rd, 32'h0000A5A5);
        access(1'b1, gpdc_pkg::UNIT_SHUTOFF_OFS, 32'h00000030);
        check(unit_power_off, 16'h0030);
        access(1'b0, gpdc_pkg::GSLEEP_TRIG_OFS, 32'h0);
        check(rd, gpdc_pkg::TRIG_READ_VALUE);
        access(1'b0, 24'h000010, 32'h0);
        check(rd, 32'h0);
        check(sleeps, 0);
        sleepless = 16'h00F0;
        // Sleep with a transfer in flight, woken by interrupt then highway
        for (int s = 0; s < 2; s++) begin
            start_xfer = 1'b1;
            @(negedge clk);
            start_xfer = 1'b0;
            fork
                access(1'b1, gpdc_pkg::GSLEEP_TRIG_OFS, 32'h0);
                begin
                    n = 0;
                    while (global_sleep !== 1'b1 && n < 100) begin
                        @(negedge clk);
                        n++;
                    end
                    repeat (20) @(negedge clk);
                    check(unit_clk_off, 16'hFF0F);
                    check(unit_power_off, 16'hFF3F);
                    check({sdram_sr_req, sdram_sr_ack}, 2'b11);
                    if (s == 0) irq_accepted = 1'b1;
                    else highway_req = 1'b1;
                    repeat (6) @(negedge clk);
                    check(global_sleep, 1'b0);
                    irq_accepted = 1'b0;
                    highway_req = 1'b0;
                end
            join
            check(unit_power_off, 16'h0030);
        end
        check(sleeps, 2);
        // Reset in mid-run clears the shutoff register and every control
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check({global_sleep, sdram_sr_req, mmio_rsp.done, unit_power_off}, 19'h0);
        stop_test;
    end
endmodule : gpdc_seq_tb
`default_nettype wire
